// [testbench.sv]
/*
  testbench: drives the setup loader through the keypad model.
  Assumes the register map and reset values of vpsc_pkg.
*/
`timescale 1ns/1ps
module testbench;
  import vpsc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic pilotWindowJumper = 1'b1;
  logic sparkWithProvingJumper = 1'b0;
  logic startupInterlockJumper = 1'b1;
  logic heatDemand = 1'b0;
  logic resetButton, regWr, regRd, fanOn, directSpark, interlockCheckEn, releasePrompt;
  logic bothValvesInPilot, seatDownstreamBefore, seatUpstreamAfter;
  logic [3:0] regAddr;
  logic [15:0] regWrData, regRdData, v;
  logic [5:0] pilotFlameWindowS;
  int n_mismatch = 0;
  int samples_checked = 0;
  always #25 clk_sys = ~clk_sys;
  vpsc_keypad_model kdu (.clk_sys(clk_sys), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .resetButton(resetButton));
  // shortened commit hold so the run can reach the commit
  vpsc_setup_config #(.HOLD_CYC(2000)) dut (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .pilotWindowJumper(pilotWindowJumper), .sparkWithProvingJumper(sparkWithProvingJumper),
    .startupInterlockJumper(startupInterlockJumper), .heatDemand(heatDemand),
    .resetButton(resetButton), .fanOn(fanOn), .pilotFlameWindowS(pilotFlameWindowS),
    .mainFlameWindowS(), .directSpark(directSpark), .interlockCheckEn(interlockCheckEn),
    .bothValvesInPilot(bothValvesInPilot), .testBefore(), .testAfter(),
    .seatDownstreamBefore(seatDownstreamBefore), .seatUpstreamAfter(seatUpstreamAfter),
    .releasePrompt(releasePrompt));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic look(input logic [3:0] a, input logic [15:0] exp, input string what);
    kdu.rd(a, v);
    check(what, v, exp);
  endtask : look
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (100000) @(posedge clk_sys);
    n_mismatch++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    look(REG_SCHED, 16'h0000, "sched rst");
    look(REG_PURGE, {4'h0, POSTPURGE_RST_S}, "purge rst");
    kdu.wr(REG_SEQ, 16'h0002);
    kdu.key(KEY_SCROLL, 1);
    look(REG_SCREEN, 16'h0000, "hidden");
    look(REG_TIME, 16'h0000, "run time");
    kdu.wr(REG_SEQ, 16'h0001);
    kdu.login(7, 7);
    look(REG_SCREEN, {12'h000, SCR_STANDBY}, "bad pass");
    kdu.login(7, 8);
    look(REG_SCREEN, {12'h000, SCR_SELECT}, "pass");
    kdu.key(KEY_DOWN, 1);
    for (int i = 1; i <= 5; i++) begin
      kdu.key(KEY_UP, 1);
      look(REG_PEND_SCHED, 16'(i % 5), "cycle");
    end
    kdu.key(KEY_UP, 4);
    kdu.key(KEY_ENTER, 1);
    kdu.key(KEY_PLUS, 61);
    look(REG_PEND_TIME, 16'h0046, "time up");
    kdu.key(KEY_MINUS, 2);
    look(REG_PEND_TIME, 16'h003B, "time down");
    kdu.key(KEY_PLUS, 56);
    look(REG_PEND_TIME, 16'h0294, "time min");
    kdu.key(KEY_ENTER, 1);
    kdu.key(KEY_PLUS, 150);
    look(REG_PEND_PURGE, {4'h0, TIME_MAX_S}, "purge max");
    kdu.key(KEY_MINUS, 1);
    look(REG_PEND_PURGE, 16'h0DD4, "purge down");
    kdu.key(KEY_ENTER, 1);
    kdu.key(KEY_UP, 1);
    look(REG_SCREEN, {12'h000, SCR_SCHED}, "back");
    kdu.key(KEY_ENTER, 3);
    kdu.key(KEY_DOWN, 1);
    look(REG_SCREEN, {12'h000, SCR_DONE}, "done");
    kdu.hold(1000);
    look(REG_SCHED, 16'h0000, "short hold");
    check("prompt", {15'h0, releasePrompt}, 16'h0000);
    fork
      kdu.hold(2100);
      begin
        repeat (2050) @(posedge clk_sys);
        #1;
        check("prompt on", {15'h0, releasePrompt}, 16'h0001);
      end
    join
    look(REG_SCHED, 16'h0004, "committed");
    kdu.wr(REG_SEQ, 16'h0002);
    look(REG_SCREEN, 16'h0000, "forced");
    look(REG_SCHED, 16'h0004, "run sched");
    look(REG_TIME, 16'h0294, "run time set");
    look(REG_PURGE, 16'h0DD4, "run purge");
    look(REG_DIAG, 16'h0000, "diag split");
    check("seat down", {15'h0, seatDownstreamBefore}, 16'h0001);
    check("seat up", {15'h0, seatUpstreamAfter}, 16'h0001);
    for (int j = 0; j < 8; j++) begin
      @(posedge clk_sys);
      {startupInterlockJumper, sparkWithProvingJumper, pilotWindowJumper} <= 3'(j);
      @(posedge clk_sys);
      #1;
      check("pilot", {10'h0, pilotFlameWindowS}, j[1] ? 16'h0 : (j[0] ? 16'hA : 16'h4));
      check("spark", {15'h0, directSpark}, {15'h0, j[1]});
      check("ilk", {15'h0, interlockCheckEn}, {15'h0, !j[2]});
      check("both", {15'h0, bothValvesInPilot}, {15'h0, j[1]});
    end
    @(posedge clk_sys);
    heatDemand <= 1'b1;
    repeat (4) @(posedge clk_sys);
    heatDemand <= 1'b0;
    repeat (10) @(posedge clk_sys);
    #1;
    check("fan", {15'h0, fanOn}, 16'h0001);
    report_and_stop();
  end
endmodule : testbench

// [vpsc_keypad_model.sv]
/*
  vpsc_keypad_model: keypad display unit driving the loader register port.
  Assumes reads return data the cycle after the strobe.
*/
`timescale 1ns/1ps
module vpsc_keypad_model
  import vpsc_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // register port
  output logic [3:0] regAddr,
  output logic [15:0] regWrData,
  output logic regWr,
  output logic regRd,
  input wire logic [15:0] regRdData,
  // module reset button
  output logic resetButton
);
  initial begin
    regAddr = 4'h0;
    regWrData = 16'h0000;
    regWr = 1'b0;
    regRd = 1'b0;
    resetButton = 1'b0;
  end
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    regWrData <= ~d;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask : rd
  task automatic key(input int unsigned k, input int unsigned n);
    repeat (n) wr(REG_KEY, 16'h0001 << k);
  endtask : key
  // scroll to setup, two digits, shift between, confirm
  task automatic login(input int unsigned d0, input int unsigned d1);
    key(KEY_SCROLL, 1);
    key(KEY_RIGHT, 1);
    key(KEY_PLUS, d0);
    key(KEY_RIGHT, 1);
    key(KEY_PLUS, d1);
    key(KEY_ENTER, 1);
  endtask : login
  task automatic hold(input int unsigned n);
    @(posedge clk_sys);
    resetButton <= 1'b1;
    repeat (n) @(posedge clk_sys);
    resetButton <= 1'b0;
  endtask : hold
endmodule : vpsc_keypad_model

// [vpsc_pkg.sv]
/*
  vpsc_pkg: constants, types and register map for the valve proving setup loader.
  Assumes a 20 MHz system clock and a simple address/strobe register port.
*/
package vpsc_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  // commit hold time and jumper-set flame windows in seconds
  localparam int unsigned COMMIT_HOLD_S = 5;
  localparam int unsigned COMMIT_HOLD_CYC = COMMIT_HOLD_S * CLK_HZ;
  localparam int unsigned SEC_TICK_CYC = CLK_HZ;
  localparam logic [5:0] PILOT_LONG_S = 6'h0A;
  localparam logic [5:0] PILOT_SHORT_S = 6'h04;
  localparam logic [5:0] MAIN_SPARK_S = 6'h04;
  // password digits
  localparam logic [3:0] PASS_DIGIT0 = 4'h7;
  localparam logic [3:0] PASS_DIGIT1 = 4'h8;
  // time values held in seconds
  localparam logic [11:0] TIME_MAX_S = 12'hE10;
  localparam logic [11:0] TIER1_TOP_S = 12'h03C;
  localparam logic [11:0] TIER2_TOP_S = 12'h258;
  localparam logic [11:0] STEP1_S = 12'h001;
  localparam logic [11:0] STEP2_S = 12'h00A;
  localparam logic [11:0] STEP3_S = 12'h03C;
  localparam logic [11:0] POSTPURGE_RST_S = 12'h00F;
  localparam logic [11:0] TESTTIME_RST_S = 12'h000;
  // register offsets
  localparam logic [3:0] REG_KEY = 4'h0;
  localparam logic [3:0] REG_SEQ = 4'h1;
  localparam logic [3:0] REG_SCREEN = 4'h2;
  localparam logic [3:0] REG_DIGITS = 4'h3;
  localparam logic [3:0] REG_PEND_SCHED = 4'h4;
  localparam logic [3:0] REG_PEND_TIME = 4'h5;
  localparam logic [3:0] REG_PEND_PURGE = 4'h6;
  localparam logic [3:0] REG_SCHED = 4'h7;
  localparam logic [3:0] REG_TIME = 4'h8;
  localparam logic [3:0] REG_PURGE = 4'h9;
  localparam logic [3:0] REG_JUMPER = 4'hA;
  localparam logic [3:0] REG_DIAG = 4'hB;
  // key bits in the key register
  localparam int unsigned KEY_UP = 0;
  localparam int unsigned KEY_DOWN = 1;
  localparam int unsigned KEY_PLUS = 2;
  localparam int unsigned KEY_MINUS = 3;
  localparam int unsigned KEY_RIGHT = 4;
  localparam int unsigned KEY_ENTER = 5;
  localparam int unsigned KEY_SCROLL = 6;

  typedef enum logic [2:0] {
    SCHED_NEVER = 3'h0, SCHED_BEFORE = 3'h1, SCHED_AFTER = 3'h2,
    SCHED_BOTH = 3'h3, SCHED_SPLIT = 3'h4
  } vpsc_sched_t;

  typedef enum logic [1:0] {
    SEQ_STANDBY = 2'h0, SEQ_LOCKOUT = 2'h1, SEQ_RUNNING = 2'h2, SEQ_OTHER = 2'h3
  } vpsc_seq_t;

  // Gray coded along the normal path from standby to release; the return from release to standby changes three bits
  typedef enum logic [3:0] {
    SCR_STANDBY = 4'h0, SCR_SETUP = 4'h1, SCR_PASSWORD = 4'h3, SCR_SELECT = 4'h2,
    SCR_SCHED = 4'h6, SCR_TIME = 4'h7, SCR_PURGE = 4'h5, SCR_CONFIRM = 4'h4,
    SCR_DONE = 4'hC, SCR_RELEASE = 4'hD
  } vpsc_screen_t;
endpackage : vpsc_pkg

// [vpsc_setup_config.sv]
/*
  vpsc_setup_config: keypad setup menu, password gate, commit by reset hold,
  committed readback and site jumper decode.
  Assumes keys arrive as one-cycle pulses written through the register port.
*/
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ps
module vpsc_setup_config
  import vpsc_pkg::*;
#(
  // button hold needed to commit, in clock cycles
  parameter int unsigned HOLD_CYC = COMMIT_HOLD_CYC
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdData,
  // site jumpers, high when intact
  input wire logic pilotWindowJumper,
  input wire logic sparkWithProvingJumper,
  input wire logic startupInterlockJumper,
  // burner demand and module reset button
  input wire logic heatDemand,
  input wire logic resetButton,
  // decoded outputs
  output logic fanOn,
  output logic [5:0] pilotFlameWindowS,
  output logic [5:0] mainFlameWindowS,
  output logic directSpark,
  output logic interlockCheckEn,
  output logic bothValvesInPilot,
  output logic testBefore,
  output logic testAfter,
  output logic seatDownstreamBefore,
  output logic seatUpstreamAfter,
  output logic releasePrompt
);
  vpsc_screen_t screen_q;
  vpsc_seq_t seq_q;
  logic [3:0] digit0_q, digit1_q;
  logic digitSel_q;
  vpsc_sched_t pendSched_q, sched_q;
  logic [11:0] pendTime_q, pendPurge_q, time_q, purge_q;
  logic [31:0] holdCnt_q;
  logic [24:0] secCnt_q;
  logic [11:0] purgeLeft_q;
  logic demand_q;
  logic [6:0] keys;
  logic menuOpen;

  vpsc_step_if stepBus ();
  vpsc_time_step u_step (.st(stepBus));

  assign keys = (regWr && regAddr == REG_KEY) ? regWrData[6:0] : 7'h00;
  assign menuOpen = (seq_q == SEQ_STANDBY) || (seq_q == SEQ_LOCKOUT);

  assign stepBus.cur = (screen_q == SCR_PURGE) ? pendPurge_q : pendTime_q;
  assign stepBus.up = keys[KEY_PLUS];
  assign stepBus.down = keys[KEY_MINUS];

  // sequencer state is written by the sequencer firmware port
  always_ff @(posedge clk_sys) begin
    if (rst) seq_q <= SEQ_STANDBY;
    else if (regWr && regAddr == REG_SEQ) seq_q <= vpsc_seq_t'(regWrData[1:0]);
  end

  // menu walk
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      screen_q <= SCR_STANDBY;
    end else if (!menuOpen && screen_q != SCR_RELEASE) begin
      screen_q <= SCR_STANDBY;
    end else begin
      case (screen_q)
        SCR_STANDBY: if (keys[KEY_SCROLL]) screen_q <= SCR_SETUP;
        SCR_SETUP: if (keys[KEY_RIGHT]) screen_q <= SCR_PASSWORD;
        SCR_PASSWORD: begin
          if (keys[KEY_ENTER]) begin
            if (digit0_q == PASS_DIGIT0 && digit1_q == PASS_DIGIT1) screen_q <= SCR_SELECT;
            else screen_q <= SCR_STANDBY;
          end
        end
        SCR_SELECT: if (keys[KEY_DOWN]) screen_q <= SCR_SCHED;
        SCR_SCHED: if (keys[KEY_ENTER]) screen_q <= SCR_TIME;
        SCR_TIME: if (keys[KEY_ENTER]) screen_q <= SCR_PURGE;
        SCR_PURGE: if (keys[KEY_ENTER]) screen_q <= SCR_CONFIRM;
        SCR_CONFIRM: begin
          if (keys[KEY_UP]) screen_q <= SCR_SCHED;
          else if (keys[KEY_DOWN]) screen_q <= SCR_DONE;
        end
        SCR_DONE: if (resetButton && holdCnt_q == HOLD_CYC - 1) screen_q <= SCR_RELEASE;
        SCR_RELEASE: if (!resetButton) screen_q <= SCR_STANDBY;
        default: screen_q <= SCR_STANDBY;
      endcase
    end
  end

  // password digits
  always_ff @(posedge clk_sys) begin
    if (rst || screen_q != SCR_PASSWORD) begin
      digit0_q <= 4'h0;
      digit1_q <= 4'h0;
      digitSel_q <= 1'b0;
    end else begin
      if (keys[KEY_RIGHT]) digitSel_q <= ~digitSel_q;
      if (keys[KEY_PLUS] && !digitSel_q) digit0_q <= digit0_q + 4'h1;
      if (keys[KEY_MINUS] && !digitSel_q) digit0_q <= digit0_q - 4'h1;
      if (keys[KEY_PLUS] && digitSel_q) digit1_q <= digit1_q + 4'h1;
      if (keys[KEY_MINUS] && digitSel_q) digit1_q <= digit1_q - 4'h1;
    end
  end

  // pending settings edited on the menu
  always_ff @(posedge clk_sys) begin
    if (rst || screen_q == SCR_SELECT) begin
      pendSched_q <= sched_q;
      pendTime_q <= time_q;
      pendPurge_q <= purge_q;
    end else begin
      if (screen_q == SCR_SCHED && keys[KEY_UP])
        pendSched_q <= (pendSched_q == SCHED_SPLIT) ? SCHED_NEVER
                     : vpsc_sched_t'(pendSched_q + 3'h1);
      if (screen_q == SCR_SCHED && keys[KEY_DOWN])
        pendSched_q <= (pendSched_q == SCHED_NEVER) ? SCHED_SPLIT
                     : vpsc_sched_t'(pendSched_q - 3'h1);
      if (screen_q == SCR_TIME) pendTime_q <= stepBus.nxt;
      if (screen_q == SCR_PURGE) pendPurge_q <= stepBus.nxt;
    end
  end

  // reset hold count and commit
  always_ff @(posedge clk_sys) begin
    if (rst || screen_q != SCR_DONE || !resetButton) holdCnt_q <= 32'h0;
    else holdCnt_q <= holdCnt_q + 32'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sched_q <= SCHED_NEVER;
      time_q <= TESTTIME_RST_S;
      purge_q <= POSTPURGE_RST_S;
    end else if (screen_q == SCR_DONE && resetButton && holdCnt_q == HOLD_CYC - 1) begin
      sched_q <= pendSched_q;
      time_q <= pendTime_q;
      purge_q <= pendPurge_q;
    end
  end

  assign releasePrompt = (screen_q == SCR_RELEASE);

  // postpurge timer from a one-second enable
  always_ff @(posedge clk_sys) begin
    if (rst || secCnt_q == 25'(SEC_TICK_CYC - 1)) secCnt_q <= 25'h0;
    else secCnt_q <= secCnt_q + 25'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      demand_q <= 1'b0;
      purgeLeft_q <= 12'h000;
    end else begin
      demand_q <= heatDemand;
      if (heatDemand) purgeLeft_q <= 12'h000;
      else if (demand_q) purgeLeft_q <= purge_q;
      else if (secCnt_q == 25'(SEC_TICK_CYC - 1) && purgeLeft_q != 12'h000)
        purgeLeft_q <= purgeLeft_q - 12'h001;
    end
  end

  assign fanOn = heatDemand || (purgeLeft_q != 12'h000) || (demand_q && purge_q != 12'h000);

  // jumper and schedule decode
  assign directSpark = sparkWithProvingJumper;
  assign interlockCheckEn = ~startupInterlockJumper;
  assign pilotFlameWindowS = directSpark ? 6'h00
                           : (pilotWindowJumper ? PILOT_LONG_S : PILOT_SHORT_S);
  assign mainFlameWindowS = MAIN_SPARK_S;
  assign bothValvesInPilot = directSpark && sched_q != SCHED_NEVER;
  assign testBefore = sched_q == SCHED_BEFORE || sched_q == SCHED_BOTH;
  assign testAfter = sched_q == SCHED_AFTER || sched_q == SCHED_BOTH;
  assign seatDownstreamBefore = sched_q == SCHED_SPLIT;
  assign seatUpstreamAfter = sched_q == SCHED_SPLIT;

  // read port, data one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (rst) regRdData <= 16'h0000;
    else if (regRd) begin
      case (regAddr)
        REG_SEQ: regRdData <= {14'h0, seq_q};
        REG_SCREEN: regRdData <= {12'h0, screen_q};
        REG_DIGITS: regRdData <= {7'h0, digitSel_q, digit1_q, digit0_q};
        REG_PEND_SCHED: regRdData <= {13'h0, pendSched_q};
        REG_PEND_TIME: regRdData <= {4'h0, pendTime_q};
        REG_PEND_PURGE: regRdData <= {4'h0, pendPurge_q};
        REG_SCHED: regRdData <= {13'h0, sched_q};
        REG_TIME: regRdData <= {4'h0, time_q};
        REG_PURGE: regRdData <= {4'h0, purge_q};
        REG_JUMPER: regRdData <= {13'h0, startupInterlockJumper, sparkWithProvingJumper,
                                  pilotWindowJumper};
        REG_DIAG: regRdData <= {12'h0, fanOn, releasePrompt, testAfter, testBefore};
        default: regRdData <= 16'h0000;
      endcase
    end else regRdData <= 16'h0000;
  end
endmodule : vpsc_setup_config

// [vpsc_setup_config_props.sv]
/*
  vpsc_setup_config_props: port assertions for the setup loader.
  Assumes clk_sys and a synchronous active-high rst.
*/
`timescale 1ns/1ps
module vpsc_setup_config_props
  import vpsc_pkg::*;
#(
  // button hold needed to commit, in clock cycles
  parameter int unsigned HOLD_CYC = COMMIT_HOLD_CYC
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // jumpers, demand and button
  input wire logic pilotWindowJumper,
  input wire logic sparkWithProvingJumper,
  input wire logic startupInterlockJumper,
  input wire logic heatDemand,
  input wire logic resetButton,
  // decoded outputs
  input wire logic fanOn,
  input wire logic [5:0] pilotFlameWindowS,
  input wire logic [5:0] mainFlameWindowS,
  input wire logic directSpark,
  input wire logic interlockCheckEn,
  input wire logic bothValvesInPilot,
  input wire logic seatDownstreamBefore,
  input wire logic seatUpstreamAfter,
  input wire logic releasePrompt
);
  logic [26:0] holdCnt_q;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // consecutive cycles with the button held
  always_ff @(posedge clk_sys) begin
    if (rst || !resetButton) holdCnt_q <= 27'h0;
    else if (holdCnt_q != 27'h7FFFFFF) holdCnt_q <= holdCnt_q + 27'h1;
  end
  pilot_window_a: assert property (
    !directSpark |-> pilotFlameWindowS == (pilotWindowJumper ? PILOT_LONG_S : PILOT_SHORT_S))
    else $error("pilot window wrong");
  spark_mode_a: assert property (directSpark == sparkWithProvingJumper)
    else $error("spark mode wrong");
  spark_window_a: assert property (
    directSpark |-> mainFlameWindowS == MAIN_SPARK_S && pilotFlameWindowS == 6'h00)
    else $error("spark windows wrong");
  interlock_check_a: assert property (interlockCheckEn == !startupInterlockJumper)
    else $error("interlock check wrong");
  both_valves_a: assert property (bothValvesInPilot |-> directSpark)
    else $error("both valves without spark");
  fan_demand_a: assert property (heatDemand |-> fanOn)
    else $error("fan off under demand");
  purge_hold_a: assert property ($fell(heatDemand) |-> fanOn [*8])
    else $error("fan dropped at demand end");
  split_seat_a: assert property (seatDownstreamBefore == seatUpstreamAfter)
    else $error("split seat tests differ");
  commit_hold_a: assert property (
    $rose(releasePrompt) |-> holdCnt_q >= HOLD_CYC - 1)
    else $error("commit without full hold");
  release_drop_a: assert property (releasePrompt && !resetButton |=> !releasePrompt)
    else $error("release prompt stuck");
  demand_end_c: cover property ($fell(heatDemand));
  spark_c: cover property (directSpark && !pilotWindowJumper);
  hold_c: cover property (resetButton [*8]);
endmodule : vpsc_setup_config_props
bind vpsc_setup_config vpsc_setup_config_props #(.HOLD_CYC(HOLD_CYC)) u_props (
  .clk_sys(clk_sys), .rst(rst),
  .pilotWindowJumper(pilotWindowJumper), .sparkWithProvingJumper(sparkWithProvingJumper),
  .startupInterlockJumper(startupInterlockJumper), .heatDemand(heatDemand),
  .resetButton(resetButton), .fanOn(fanOn), .pilotFlameWindowS(pilotFlameWindowS),
  .mainFlameWindowS(mainFlameWindowS), .directSpark(directSpark),
  .interlockCheckEn(interlockCheckEn), .bothValvesInPilot(bothValvesInPilot),
  .seatDownstreamBefore(seatDownstreamBefore), .seatUpstreamAfter(seatUpstreamAfter),
  .releasePrompt(releasePrompt));

// [vpsc_step_if.sv]
/*
  vpsc_step_if: carries a time value and up/down requests to the stepper.
  Assumes the stepper is combinational.
*/
`timescale 1ns/1ps
interface vpsc_step_if;
  logic [11:0] cur;
  logic up;
  logic down;
  logic [11:0] nxt;
  modport ctrl (output cur, output up, output down, input nxt);
  modport step (input cur, input up, input down, output nxt);
endinterface : vpsc_step_if

// [vpsc_time_step.sv]
/*
  vpsc_time_step: three-tier time stepping for the setup times.
  Assumes inputs are sampled by the caller.
*/
`timescale 1ns/1ps
module vpsc_time_step
  import vpsc_pkg::*;
(
  // step request
  vpsc_step_if.step st
);
  always_comb begin
    st.nxt = st.cur;
    if (st.up && st.cur < TIME_MAX_S) begin
      if (st.cur < TIER1_TOP_S) st.nxt = st.cur + STEP1_S;
      else if (st.cur < TIER2_TOP_S) st.nxt = st.cur + STEP2_S;
      else st.nxt = st.cur + STEP3_S;
    end else if (st.down && st.cur != 12'h000) begin
      if (st.cur <= TIER1_TOP_S) st.nxt = st.cur - STEP1_S;
      else if (st.cur <= TIER2_TOP_S) st.nxt = st.cur - STEP2_S;
      else st.nxt = st.cur - STEP3_S;
    end
  end
endmodule : vpsc_time_step
